// ---- core/sysctl_cache_pkg.sv ----
// Purpose: Shared constants and carrier types for the cache configuration register bank.
// Assumes: Host I/O cycles arrive already decoded on the CPU bus clock (250 MHz).
// Notes:   Every offset, field position, reset value and timing count is named here once.
package sysctl_cache_pkg;

   // I/O ports used by the indexed access scheme and the keyboard command port.
   localparam logic [15:0] PORT_INDEX    = 16'h0022;
   localparam logic [15:0] PORT_DATA     = 16'h0024;
   localparam logic [15:0] PORT_KBD_CMD  = 16'h0064;

   // Register indexes.
   localparam logic [7:0] IDX_CONTROL_ONE      = 8'h20;
   localparam logic [7:0] IDX_CACHE_DRAM       = 8'h21;
   localparam logic [7:0] IDX_NC1_SIZE_HIGH    = 8'h28;
   localparam logic [7:0] IDX_NC1_ADDR_LOW     = 8'h29;
   localparam logic [7:0] IDX_NC2_SIZE_HIGH    = 8'h2A;
   localparam logic [7:0] IDX_NC2_ADDR_LOW     = 8'h2B;
   localparam logic [7:0] IDX_UNDECODED        = 8'h2C;
   localparam logic [7:0] IDX_IRQ_ROM_SELECT   = 8'h2D;
   localparam logic [7:0] IDX_RANGE_UPPER      = 8'h2E;
   localparam logic [7:0] IDX_RANGE_LOWER      = 8'h2F;

   // Reset values of the registers.
   localparam logic [7:0] RST_CONTROL_ONE      = 8'h00;
   localparam logic [7:0] RST_CACHE_DRAM       = 8'h00;
   localparam logic [7:0] RST_NC_SIZE_HIGH     = 8'h00;
   localparam logic [7:0] RST_NC_ADDR_LOW      = 8'h00;
   localparam logic [7:0] RST_IRQ_ROM_SELECT   = 8'h00;
   localparam logic [7:0] RST_RANGE_UPPER      = 8'h00;
   localparam logic [7:0] RST_RANGE_LOWER      = 8'h00;
   localparam logic [7:0] RST_INDEX            = 8'h00;

   // Value returned for an index that this bank does not decode.
   localparam logic [7:0] UNMAPPED_READ        = 8'hFF;

   // Silicon revision code; the value is arbitrary.
   localparam logic [1:0] REVISION_CODE        = 2'b11;

   // Field positions in control_one.
   localparam int CTL1_REV_LSB        = 6;
   localparam int CTL1_BURST_TWO      = 5;
   localparam int CTL1_TAG_BIT_SEVEN_DISABLE   = 4;
   localparam int CTL1_SINGLE_ALE     = 3;
   localparam int CTL1_AT_WAIT        = 2;
   localparam int CTL1_KBD_IMMEDIATE  = 1;
   localparam int CTL1_FAST_RESET     = 0;

   // Field positions in cache_dram_control.
   localparam int CDC_BYTE_SWAP       = 7;
   localparam int CDC_DEBUG           = 6;
   localparam int CDC_PARITY_DISABLE  = 5;
   localparam int CDC_L2_ENABLE       = 4;
   localparam int CDC_L2_SIZE_LSB     = 2;
   localparam int CDC_WRITE_ZERO_WAIT = 1;
   localparam int CDC_READ_TWO_CLK    = 0;

   // Field positions in the non-cacheable block size/high register.
   localparam int NC_SIZE_LSB         = 5;
   localparam int NC_HIGH_LSB         = 0;

   // Field positions in irq_latch_rom_select.
   localparam int IRS_IRQ12_LATCH     = 7;
   localparam int IRS_IRQ1_LATCH      = 6;
   localparam int IRS_ROM_CS_LSB      = 0;

   // Field positions in cacheability_range_upper.
   localparam int RNG_L1_LSB          = 4;
   localparam int RNG_L2_E_LSB        = 0;

   // Leadoff timing figures: read leadoff in clocks, write leadoff in wait states.
   localparam logic [1:0] LEADOFF_TWO    = 2'd2;
   localparam logic [1:0] LEADOFF_THREE  = 2'd3;
   localparam logic [1:0] WAIT_NONE      = 2'd0;
   localparam logic [1:0] WAIT_ONE       = 2'd1;

   // CPU reset pulse width.
   localparam int CLK_PERIOD_NS       = 4;
   localparam int RESET_PULSE_NS      = 64;
   localparam int RESET_PULSE_CYCLES  = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] RESET_PULSE_LAST = 5'(RESET_PULSE_CYCLES - 1);

   // Strap sampling waits this many cycles after reset release.
   localparam logic [1:0] STRAP_TAKE_AGE = 2'd2;

   // One host I/O cycle, a single clock wide.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } io_req_t;

   // Settings driven to the cache, DRAM and bus controllers.
   typedef struct packed {
      logic       burst_two_clocks;
      logic       tag_bit_seven_sample_en;
      logic       single_ale;
      logic       at_wait_state;
      logic       byte_swap_en;
      logic       parity_check_en;
      logic       l2_enable;
      logic [1:0] l2_size;
      logic [1:0] write_leadoff_waits;
      logic [1:0] read_leadoff_clocks;
      logic       irq12_latch_en;
      logic       irq1_latch_en;
      logic [5:0] rom_chip_select_en;
   } config_out_t;

   // Attributes of the memory address currently on the bus.
   typedef struct packed {
      logic noncacheable;
      logic l1_cacheable;
      logic l2_cacheable;
   } mem_attr_t;

   // CPU reset generator states.
   typedef enum logic [0:0] {
      RST_IDLE,
      RST_PULSE
   } rst_state_t;

endpackage

// ---- core/noncache_block_match.sv ----
// Purpose: Tests one memory address against one non-cacheable block descriptor.
// Assumes: Address bits 26:16 are presented; lower bits never affect a 64KB-grained block.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module noncache_block_match
   import sysctl_cache_pkg::*;
(
   input  wire logic [7:0]  size_high_i,   // Size field and address bits 26:24.
   input  wire logic [7:0]  addr_low_i,    // Address bits 23:16.
   input  wire logic [10:0] mem_addr_i,    // Bus address bits 26:16.
   output logic             hit_o          // Address lies inside the block.
);

   // Mask of address bits compared for a size code: code n covers 64KB shifted by n-1.
   function automatic logic [10:0] size_mask(input logic [2:0] code);
      logic [10:0] m;
      m = 11'h7FF;
      if (code > 3'd1) begin
         m = 11'h7FF << (code - 3'd1);
      end
      return m;
   endfunction

   logic [2:0]  size_code;  // Encoded block size, zero turns the block off.
   logic [10:0] base;       // Block base, address bits 26:16.
   logic [10:0] mask;       // Bits compared between base and address.

   // A block is live only with a non-zero size; base bits below the size are ignored.
   always_comb begin
      size_code = size_high_i[NC_SIZE_LSB +: 3];
      base      = {size_high_i[NC_HIGH_LSB +: 3], addr_low_i};
      mask      = size_mask(size_code);
      hit_o     = (size_code != 3'd0) && (((mem_addr_i ^ base) & mask) == 11'h000);
   end

endmodule

// ---- core/sysctl_cache_config_regs.sv ----
// Purpose: Cache and CPU-control configuration registers reached by indexed I/O cycles.
// Assumes: Host cycles, halt and dirty indications come from logic on clk_i; the strap is a pin.
// Notes:   All outputs are registered; settings follow a register write by one cycle.
`timescale 1ns/1ns
module sysctl_cache_config_regs
   import sysctl_cache_pkg::*;
(
   input  wire logic        clk_i,              // CPU bus clock.
   input  wire logic        arst_n_i,           // Asynchronous system reset, active low.
   input  wire io_req_t     io_req_i,           // One-cycle host I/O request.
   input  wire logic        halt_i,             // One-cycle pulse: processor halt cycle seen.
   input  wire logic        cache_mode_strap_i, // Cache mode strap pin.
   input  wire logic        line_dirty_i,       // Target L2 line of the current write is dirty.
   input  wire logic [26:0] mem_addr_i,         // Current memory bus address.
   output logic [7:0]       io_rdata_o,         // Read data for the request of the previous cycle.
   output logic             io_rdata_valid_o,   // One-cycle pulse marking io_rdata_o.
   output logic             cpu_reset_o,        // CPU reset pulse.
   output config_out_t      config_o,           // Decoded settings for the controllers.
   output mem_attr_t        mem_attr_o          // Cacheability of mem_addr_i, one cycle late.
);

   // Complete state of the block, registered as one word.
   typedef struct packed {
      logic [7:0]  index;            // Index latched through port 22h.
      logic [7:0]  control_one;      // Writable bits of control_one; 7:6 unused here.
      logic [7:0]  cache_dram;       // cache_dram_control.
      logic [7:0]  nc1_size_high;    // nocache_block1_size_high.
      logic [7:0]  nc1_addr_low;     // nocache_block1_addr_low.
      logic [7:0]  nc2_size_high;    // nocache_block2_size_high.
      logic [7:0]  nc2_addr_low;     // nocache_block2_addr_low.
      logic [7:0]  irq_rom;          // irq_latch_rom_select.
      logic [7:0]  range_upper;      // cacheability_range_upper.
      logic [7:0]  range_lower;      // cacheability_range_lower.
      logic [1:0]  strap_sync;       // Two-stage synchroniser for the strap pin.
      logic [1:0]  strap_age;        // Cycles since reset release, saturating.
      logic        strap_high;       // Strap level caught after reset release.
      logic        kbd_pending;      // Port 64h written; waiting for a halt.
      rst_state_t  rst_state;        // CPU reset generator state.
      logic [4:0]  rst_cnt;          // Cycles elapsed in the reset pulse.
      logic        cpu_reset;        // Registered reset output.
      logic [7:0]  rdata;            // Registered read data.
      logic        rvalid;           // Registered read strobe.
      config_out_t cfg;              // Registered settings.
      mem_attr_t   attr;             // Registered address attributes.
   } state_t;

   localparam state_t STATE_RESET = '{
      index:        RST_INDEX,
      control_one:  RST_CONTROL_ONE,
      cache_dram:   RST_CACHE_DRAM,
      nc1_size_high: RST_NC_SIZE_HIGH,
      nc1_addr_low: RST_NC_ADDR_LOW,
      nc2_size_high: RST_NC_SIZE_HIGH,
      nc2_addr_low: RST_NC_ADDR_LOW,
      irq_rom:      RST_IRQ_ROM_SELECT,
      range_upper:  RST_RANGE_UPPER,
      range_lower:  RST_RANGE_LOWER,
      strap_sync:   2'b00,
      strap_age:    2'b00,
      strap_high:   1'b0,
      kbd_pending:  1'b0,
      rst_state:    RST_IDLE,
      rst_cnt:      5'h00,
      cpu_reset:    1'b0,
      rdata:        8'h00,
      rvalid:       1'b0,
      cfg:          '0,
      attr:         '0
   };

   logic [1:0] rst_sync;    // Reset release synchroniser.
   logic       rst_n;       // Synchronised reset used by the rest of the block.
   state_t     st;          // Current state.
   state_t     next_st;     // Next state.
   logic       nc1_hit;     // Address inside block one.
   logic       nc2_hit;     // Address inside block two.

   // Reset is applied at once but released only after two clean clock edges.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Both descriptors share one matcher design.
   noncache_block_match u_block1 (
      .size_high_i (st.nc1_size_high),
      .addr_low_i  (st.nc1_addr_low),
      .mem_addr_i  (mem_addr_i[26:16]),
      .hit_o       (nc1_hit)
   );

   noncache_block_match u_block2 (
      .size_high_i (st.nc2_size_high),
      .addr_low_i  (st.nc2_addr_low),
      .mem_addr_i  (mem_addr_i[26:16]),
      .hit_o       (nc2_hit)
   );

   // Read view of an index; shared by the data-port read path.
   function automatic logic [7:0] read_view(input state_t s, input logic [7:0] idx);
      logic [7:0] v;
      v = UNMAPPED_READ;
      case (idx)
         IDX_CONTROL_ONE: begin
            v = {REVISION_CODE, s.control_one[CTL1_REV_LSB-1:0]};
         end
         IDX_CACHE_DRAM: begin
            v = s.cache_dram;
         end
         IDX_NC1_SIZE_HIGH: begin
            v = s.nc1_size_high;
         end
         IDX_NC1_ADDR_LOW: begin
            v = s.nc1_addr_low;
         end
         IDX_NC2_SIZE_HIGH: begin
            v = s.nc2_size_high;
         end
         IDX_NC2_ADDR_LOW: begin
            v = s.nc2_addr_low;
         end
         IDX_IRQ_ROM_SELECT: begin
            v = s.irq_rom;
         end
         IDX_RANGE_UPPER: begin
            v = s.range_upper;
         end
         IDX_RANGE_LOWER: begin
            v = s.range_lower;
         end
         default: begin
            // Index 2Ch and anything else read as the unmapped value.
            v = UNMAPPED_READ;
         end
      endcase
      return v;
   endfunction

   // Whole next-state computation: register writes, reset generator, decoded settings.
   always_comb begin
      logic       wr_data;       // Write to the data port.
      logic       wr_kbd;        // Write to the keyboard command port.
      logic       fire;          // A CPU reset pulse must start.
      logic       in_upper;      // Address lies in C0000h-FFFFFh.
      logic [1:0] seg64;         // 64KB segment index within C0000h-FFFFFh.
      logic [3:0] seg16;         // 16KB segment index within C0000h-EFFFFh.
      logic [11:0] l2_bits;      // L2 segment enables, C0000h upward.
      wr_data  = 1'b0;
      wr_kbd   = 1'b0;
      fire     = 1'b0;
      in_upper = 1'b0;
      seg64    = 2'b00;
      seg16    = 4'h0;
      l2_bits  = 12'h000;
      next_st  = st;

      wr_data = io_req_i.wr && (io_req_i.addr == PORT_DATA);
      wr_kbd  = io_req_i.wr && (io_req_i.addr == PORT_KBD_CMD);

      // Index port latch.
      if (io_req_i.wr && (io_req_i.addr == PORT_INDEX)) begin
         next_st.index = io_req_i.wdata;
      end

      // Data port writes land in the register selected by the index.
      if (wr_data) begin
         case (st.index)
            IDX_CONTROL_ONE: begin
               // The revision bits are not stored, so writes to them vanish.
               next_st.control_one = {2'b00, io_req_i.wdata[CTL1_REV_LSB-1:0]};
            end
            IDX_CACHE_DRAM: begin
               // The debug bit is stored as written; software keeps it at zero.
               next_st.cache_dram = io_req_i.wdata;
            end
            IDX_NC1_SIZE_HIGH: begin
               next_st.nc1_size_high = io_req_i.wdata;
            end
            IDX_NC1_ADDR_LOW: begin
               next_st.nc1_addr_low = io_req_i.wdata;
            end
            IDX_NC2_SIZE_HIGH: begin
               next_st.nc2_size_high = io_req_i.wdata;
            end
            IDX_NC2_ADDR_LOW: begin
               next_st.nc2_addr_low = io_req_i.wdata;
            end
            IDX_IRQ_ROM_SELECT: begin
               next_st.irq_rom = io_req_i.wdata;
            end
            IDX_RANGE_UPPER: begin
               next_st.range_upper = io_req_i.wdata;
            end
            IDX_RANGE_LOWER: begin
               next_st.range_lower = io_req_i.wdata;
            end
            default: begin
               // Undecoded indexes, 2Ch among them, ignore the write.
               next_st.index = st.index;
            end
         endcase
      end

      // Reads of the data port answer one cycle later; the index port reads back too.
      next_st.rvalid = io_req_i.rd && ((io_req_i.addr == PORT_DATA) || (io_req_i.addr == PORT_INDEX));
      if (io_req_i.rd && (io_req_i.addr == PORT_INDEX)) begin
         next_st.rdata = st.index;
      end else if (io_req_i.rd && (io_req_i.addr == PORT_DATA)) begin
         next_st.rdata = read_view(st, st.index);
      end

      // The strap is sampled a fixed number of cycles after release, once the
      // synchroniser holds a real pin level instead of its reset value.
      next_st.strap_sync = {st.strap_sync[0], cache_mode_strap_i};
      if (st.strap_age != 2'b11) begin
         next_st.strap_age = st.strap_age + 2'b01;
      end
      if (st.strap_age == STRAP_TAKE_AGE) begin
         next_st.strap_high = st.strap_sync[1];
      end

      // Keyboard emulation reset: immediate, or armed until the next halt.
      if (wr_kbd && st.control_one[CTL1_KBD_IMMEDIATE]) begin
         fire = 1'b1;
      end else if (wr_kbd) begin
         next_st.kbd_pending = 1'b1;
      end
      if (halt_i && st.kbd_pending) begin
         fire                = 1'b1;
         next_st.kbd_pending = 1'b0;
      end
      // Fast reset on every halt when enabled.
      if (halt_i && st.control_one[CTL1_FAST_RESET]) begin
         fire = 1'b1;
      end

      // Reset pulse generator; a request during a pulse is absorbed by it.
      case (st.rst_state)
         RST_IDLE: begin
            next_st.cpu_reset = 1'b0;
            next_st.rst_cnt   = 5'h00;
            if (fire) begin
               next_st.rst_state   = RST_PULSE;
               next_st.cpu_reset   = 1'b1;
               // A pulse resets the processor, so a pending halt request is moot.
               next_st.kbd_pending = 1'b0;
            end
         end
         RST_PULSE: begin
            next_st.kbd_pending = 1'b0;
            if (st.rst_cnt == RESET_PULSE_LAST) begin
               next_st.rst_state = RST_IDLE;
               next_st.cpu_reset = 1'b0;
            end else begin
               next_st.rst_cnt = st.rst_cnt + 5'h01;
            end
         end
         default: begin
            next_st.rst_state = RST_IDLE;
            next_st.cpu_reset = 1'b0;
         end
      endcase

      // Decoded settings.
      next_st.cfg.burst_two_clocks = st.control_one[CTL1_BURST_TWO];
      // Tag sampling follows bit 4 only when the strap was low at reset.
      next_st.cfg.tag_bit_seven_sample_en = !st.strap_high && !st.control_one[CTL1_TAG_BIT_SEVEN_DISABLE];
      next_st.cfg.single_ale    = st.control_one[CTL1_SINGLE_ALE];
      next_st.cfg.at_wait_state = st.control_one[CTL1_AT_WAIT];
      next_st.cfg.byte_swap_en  = st.cache_dram[CDC_BYTE_SWAP];
      next_st.cfg.parity_check_en = !st.cache_dram[CDC_PARITY_DISABLE];
      next_st.cfg.l2_enable     = st.cache_dram[CDC_L2_ENABLE];
      next_st.cfg.l2_size       = st.cache_dram[CDC_L2_SIZE_LSB +: 2];
      // Zero-wait write leadoff still costs a wait on a clean line.
      if (!st.cache_dram[CDC_WRITE_ZERO_WAIT]) begin
         next_st.cfg.write_leadoff_waits = WAIT_ONE;
      end else if (!line_dirty_i) begin
         next_st.cfg.write_leadoff_waits = WAIT_ONE;
      end else begin
         next_st.cfg.write_leadoff_waits = WAIT_NONE;
      end
      next_st.cfg.read_leadoff_clocks = st.cache_dram[CDC_READ_TWO_CLK] ? LEADOFF_TWO : LEADOFF_THREE;
      next_st.cfg.irq12_latch_en     = st.irq_rom[IRS_IRQ12_LATCH];
      next_st.cfg.irq1_latch_en      = st.irq_rom[IRS_IRQ1_LATCH];
      next_st.cfg.rom_chip_select_en = st.irq_rom[IRS_ROM_CS_LSB +: 6];

      // Address attributes: the upper region is C0000h-FFFFFh below 1MB.
      in_upper = (mem_addr_i[26:20] == 7'h00) && (mem_addr_i[19:18] == 2'b11);
      seg64    = mem_addr_i[17:16];
      seg16    = mem_addr_i[17:14];
      l2_bits  = {st.range_upper[RNG_L2_E_LSB +: 4], st.range_lower};
      next_st.attr.noncacheable = nc1_hit || nc2_hit;
      next_st.attr.l1_cacheable = !(nc1_hit || nc2_hit) &&
                                  (!in_upper || st.range_upper[RNG_L1_LSB + 32'(seg64)]);
      // The F segment has no L2 range bits here, so it stays cacheable.
      next_st.attr.l2_cacheable = !(nc1_hit || nc2_hit) &&
                                  (!in_upper || (seg64 == 2'b11) || l2_bits[seg16]);
   end

   // Single register for the whole state word.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st <= STATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Every output is a field of the state register.
   assign io_rdata_o       = st.rdata;
   assign io_rdata_valid_o = st.rvalid;
   assign cpu_reset_o      = st.cpu_reset;
   assign config_o         = st.cfg;
   assign mem_attr_o       = st.attr;

endmodule

// ---- testbench/cfg_regs_props.sv ----
// Purpose: Port assertions for the cache configuration register bank.
// Assumes: Shadows follow host writes.
// Notes:   Setting checks wait for reset to settle.
`timescale 1ns/1ns
module cfg_regs_props
   import sysctl_cache_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire io_req_t     io_req_i,
   input  wire logic        halt_i,
   input  wire logic        line_dirty_i,
   input  wire logic [7:0]  io_rdata_o,
   input  wire logic        cpu_reset_o,
   input  wire config_out_t config_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   logic [7:0] idx, ctl1, cdc, ctl1_d, cdc_d; // Shadows, and copies one cycle older.
   logic [4:0] run;                           // Length of the current reset pulse.
   logic [2:0] age;                           // Cycles since reset release, saturating.
   logic       dirty_d;                       // Dirty flag one cycle older.
   wire        dwr = io_req_i.wr && io_req_i.addr == PORT_DATA;
   wire        drd = io_req_i.rd && io_req_i.addr == PORT_DATA;
   // Tracks what the host wrote so expectations never lean on the bank itself.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         {idx, ctl1, cdc, ctl1_d, cdc_d, run, age, dirty_d} <= '0;
      end else begin
         if (io_req_i.wr && io_req_i.addr == PORT_INDEX) idx <= io_req_i.wdata;
         if (dwr && idx == IDX_CONTROL_ONE) ctl1 <= io_req_i.wdata;
         if (dwr && idx == IDX_CACHE_DRAM) cdc <= io_req_i.wdata;
         {ctl1_d, cdc_d, dirty_d} <= {ctl1, cdc, line_dirty_i};
         run <= cpu_reset_o ? run + 5'h1 : 5'h0;
         age <= (age == 3'h7) ? age : age + 3'h1;
      end
   end
   a_revision_read: assert property (drd && idx == IDX_CONTROL_ONE
      |=> io_rdata_o == {REVISION_CODE, ctl1[5:0]}) else $error("control read wrong");
   a_unmapped_read: assert property (drd && idx == IDX_UNDECODED
      |=> io_rdata_o == UNMAPPED_READ) else $error("undecoded read wrong");
   a_fast_halt: assert property (halt_i && ctl1[CTL1_FAST_RESET] && !cpu_reset_o
      |=> cpu_reset_o) else $error("halt gave no reset");
   a_kbd_now: assert property (io_req_i.wr && io_req_i.addr == PORT_KBD_CMD && ctl1[1] && !cpu_reset_o
      |=> cpu_reset_o) else $error("keyboard write gave no reset");
   a_pulse_length: assert property ($fell(cpu_reset_o) |-> run == RESET_PULSE_LAST + 5'h1)
      else $error("reset pulse length wrong");
   a_burst_follow: assert property (age > 3'h3 |-> config_o.burst_two_clocks == ctl1_d[5]
      && config_o.single_ale == ctl1_d[3] && config_o.at_wait_state == ctl1_d[2]) else $error("control setting wrong");
   a_l2_follow: assert property (age > 3'h3 |-> config_o.l2_enable == cdc_d[4]
      && config_o.l2_size == cdc_d[3:2]) else $error("cache setting wrong");
   a_read_leadoff: assert property (age > 3'h3
      |-> config_o.read_leadoff_clocks == (cdc_d[0] ? LEADOFF_TWO : LEADOFF_THREE)) else $error("read leadoff wrong");
   a_write_leadoff: assert property (age > 3'h3
      |-> config_o.write_leadoff_waits == (cdc_d[1] && dirty_d ? WAIT_NONE : WAIT_ONE)) else $error("write leadoff wrong");
endmodule
bind sysctl_cache_config_regs cfg_regs_props u_props (.clk_i, .arst_n_i, .io_req_i, .halt_i, .line_dirty_i,
   .io_rdata_o, .cpu_reset_o, .config_o);

// ---- testbench/host_io_model.sv ----
// Purpose: Host processor issuing indexed register I/O cycles.
// Assumes: The bank takes a request at the edge after it is driven.
// Notes:   Each request is released at the edge that takes it.
`timescale 1ns/1ns
module host_io_model
   import sysctl_cache_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output io_req_t         req_o
);
   initial req_o = '0;
   // One single-cycle request; the idle cycle after it keeps drives apart.
   task automatic cycle(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_i);
      req_o <= '0;
   endtask
   task automatic put(input logic [7:0] i, input logic [7:0] d);
      cycle(1'b1, PORT_INDEX, i);
      cycle(1'b1, PORT_DATA, d);
   endtask
   // The answer lands at the taking edge, so it is read just after it.
   task automatic get(input logic [7:0] i, output logic [7:0] d);
      cycle(1'b1, PORT_INDEX, i);
      cycle(1'b0, PORT_DATA, 8'h00);
      #1 d = rdata_i;
   endtask
endmodule

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the cache configuration register bank.
// Assumes: Strap tied low.
// Notes:   Random values come from a fixed-seed xorshift.
`timescale 1ns/1ns
module tb_top
   import sysctl_cache_pkg::*;
();
   logic        clk_i = 1'b0, arst_n_i = 1'b0, halt_i = 1'b0, dirty = 1'b0, rvalid, cpu_rst;
   logic [26:0] maddr = '0;
   logic [7:0]  rdata, v, r, w, e;
   logic [31:0] seed = 32'h0000_2a4b;
   io_req_t     req;
   config_out_t cfg;
   mem_attr_t   m, attr;
   int          bad_count = 0, comparisons = 0, cycles = 0, n;
   logic [7:0]  ix [10] = '{IDX_CONTROL_ONE, IDX_CACHE_DRAM, IDX_NC1_SIZE_HIGH, IDX_NC1_ADDR_LOW, IDX_NC2_SIZE_HIGH,
                           IDX_NC2_ADDR_LOW, IDX_IRQ_ROM_SELECT, IDX_RANGE_UPPER, IDX_RANGE_LOWER, IDX_UNDECODED};
   host_io_model host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
   sysctl_cache_config_regs dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .io_req_i(req), .halt_i(halt_i),
      .cache_mode_strap_i(1'b0), .line_dirty_i(dirty), .mem_addr_i(maddr), .io_rdata_o(rdata),
      .io_rdata_valid_o(rvalid), .cpu_reset_o(cpu_rst), .config_o(cfg), .mem_attr_o(attr));
   initial forever #2 clk_i = ~clk_i;
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Counts reset-high cycles from the trigger edge on, longer than any pulse.
   task automatic pulse_len(output int c);
      c = 0;
      repeat (24) begin #1 c += (cpu_rst === 1'b1); @(posedge clk_i); end
   endtask
   task automatic probe(input logic [26:0] a, input logic [2:0] x); // Attributes arrive one cycle late.
      @(posedge clk_i);
      maddr <= a;
      repeat (2) @(posedge clk_i);
      #1 check("mem attr", {5'h0, attr}, {5'h0, x});
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         bad_count++;
         report_and_stop();
      end
   end
   initial begin
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      host.put(IDX_UNDECODED, 8'h5A);
      foreach (ix[i]) begin
         host.get(ix[i], r);
         e = (ix[i] == IDX_UNDECODED) ? UNMAPPED_READ : 8'h00;
         check("reset value", r, (ix[i] == IDX_CONTROL_ONE) ? {REVISION_CODE, 6'h00} : e);
      end
      repeat (24) begin
         v = rnd();
         w = rnd();
         dirty <= w[0];
         host.put(IDX_CONTROL_ONE, v);
         host.put(IDX_CACHE_DRAM, v & 8'hBF);
         host.get(IDX_CONTROL_ONE, r);
         check("control read", r, {REVISION_CODE, v[5:0]});
         host.get(IDX_CACHE_DRAM, r);
         check("cache read", r, v & 8'hBF);
         check("ctl cfg", {cfg.burst_two_clocks, cfg.tag_bit_seven_sample_en, cfg.single_ale, cfg.at_wait_state, 4'h0},
            {v[5], ~v[4], v[3:2], 4'h0});
         check("cache cfg", {cfg.byte_swap_en, cfg.parity_check_en, cfg.l2_enable, cfg.l2_size, 3'h0},
            {v[7], ~v[5], v[4], v[3:2], 3'h0});
         check("leadoff", {4'h0, cfg.write_leadoff_waits, cfg.read_leadoff_clocks}, {4'h0, (v[1] && w[0]) ?
            WAIT_NONE : WAIT_ONE, v[0] ? LEADOFF_TWO : LEADOFF_THREE});
      end
      for (int k = 0; k < 5; k++) begin
         host.put(IDX_CONTROL_ONE, k == 3 ? 8'h01 : (k == 0 ? 8'h02 : 8'h00));
         if (k < 2) host.cycle(1'b1, PORT_KBD_CMD, 8'hFE);
         else begin
            @(posedge clk_i) halt_i <= 1'b1;
            @(posedge clk_i) halt_i <= 1'b0;
         end
         pulse_len(n);
         check("reset pulse", 8'(n), (k == 1 || k == 4) ? 8'h00 : 8'(RESET_PULSE_CYCLES));
      end
      for (int b = 0; b < 2; b++) begin
         host.put(IDX_NC1_SIZE_HIGH + 8'(2 * b), 8'h22);
         host.put(IDX_NC1_ADDR_LOW + 8'(2 * b), 8'h34);
         probe(27'h234_5678, 3'b100);
         probe(27'h235_0000, 3'b011);
         host.put(IDX_NC1_SIZE_HIGH + 8'(2 * b), 8'h00);
      end
      host.put(IDX_CACHE_DRAM, 8'h10);
      host.put(IDX_RANGE_UPPER, 8'h10);
      host.put(IDX_RANGE_LOWER, 8'h01);
      probe(27'h00C_1234, 3'b011);
      probe(27'h00C_4000, 3'b010);
      probe(27'h00D_0000, 3'b000);
      report_and_stop();
   end
endmodule
